// ===== rtl/csfr_consts.svh
// Purpose: addresses, indices, masks and reset values of the core SPECIAL_FUNCTION_REGISTER bank
// Assumes: 12-bit data memory address, 8-bit data
// Notes: file indices count from the working register upward
`ifndef CSFR_CONSTS_SVH
`define CSFR_CONSTS_SVH

// data memory layout
`define CSFR_SFR_LO 12'hF16
`define CSFR_BANKED_HI 12'hF5F
`define CSFR_ACCESS_SPLIT 8'h60
`define CSFR_SFR_PAGE 4'hF
`define CSFR_GPR_PAGE 4'h0

// printed addresses of the bank
`define CSFR_ADDR_STACK_TOP_U 12'hFFF
`define CSFR_ADDR_STACK_TOP_H 12'hFFE
`define CSFR_ADDR_STACK_TOP_L 12'hFFD
`define CSFR_ADDR_STACK_PTR 12'hFFC
`define CSFR_ADDR_PC_LATCH_U 12'hFFB
`define CSFR_ADDR_PC_LATCH_H 12'hFFA
`define CSFR_ADDR_PC_LOW 12'hFF9
`define CSFR_ADDR_TBLU 12'hFF8
`define CSFR_ADDR_TBLH 12'hFF7
`define CSFR_ADDR_TBLL 12'hFF6
`define CSFR_ADDR_TABLE_LATCH 12'hFF5
`define CSFR_ADDR_PRODUCT_H 12'hFF4
`define CSFR_ADDR_PRODUCT_L 12'hFF3
`define CSFR_ADDR_INTC 12'hFF2
`define CSFR_ADDR_INTC_EDGES 12'hFF1
`define CSFR_ADDR_INTC_EXT 12'hFF0
`define CSFR_ADDR_P0_PLAIN 12'hFEF
`define CSFR_ADDR_P0_POSTINC 12'hFEE
`define CSFR_ADDR_P0_POSTDEC 12'hFED
`define CSFR_ADDR_P0_PREINC 12'hFEC
`define CSFR_ADDR_P0_OFFSET 12'hFEB
`define CSFR_ADDR_P0_HIGH 12'hFEA
`define CSFR_ADDR_P0_LOW 12'hFE9
`define CSFR_ADDR_WORK 12'hFE8
`define CSFR_ADDR_P1_PLAIN 12'hFE7

// register file window: address bits 11:5 all ones, low bits 08..1F
`define CSFR_FILE_TOP 7'h7F
`define CSFR_FILE_FIRST 5'h08
`define CSFR_FILE_COUNT 24

// file indices (address minus working register address)
`define CSFR_IDX_WORK 5'h00
`define CSFR_IDX_P0_LOW 5'h01
`define CSFR_IDX_P0_HIGH 5'h02
`define CSFR_IDX_P0_OFFSET 5'h03
`define CSFR_IDX_P0_PREINC 5'h04
`define CSFR_IDX_P0_POSTDEC 5'h05
`define CSFR_IDX_P0_POSTINC 5'h06
`define CSFR_IDX_P0_PLAIN 5'h07
`define CSFR_IDX_INTC_EXT 5'h08
`define CSFR_IDX_INTC_EDGES 5'h09
`define CSFR_IDX_TBLU 5'h10
`define CSFR_IDX_PC_LATCH_U 5'h13
`define CSFR_IDX_STACK_PTR 5'h14
`define CSFR_IDX_STACK_TOP_U 5'h17

// implemented-bit masks
`define CSFR_MASK_FULL 8'hFF
`define CSFR_MASK_NONE 8'h00
`define CSFR_MASK_P0_HIGH 8'h0F
`define CSFR_MASK_TBLU 8'h3F
`define CSFR_MASK_TBLU_GATED 8'h1F
`define CSFR_MASK_UPPER5 8'h1F
`define CSFR_MASK_STACK_PTR 8'hDF

// reset values
`define CSFR_RST_ZERO 8'h00
`define CSFR_RST_INTC_EDGES 8'hFF
`define CSFR_RST_INTC_EXT 8'hC0

`endif

// ===== rtl/csfr_pkg.sv
// Purpose: shared types of the core SPECIAL_FUNCTION_REGISTER bank
// Assumes: nothing beyond SystemVerilog
// Notes: mode order is free, codes are never decoded outside
package csfr_pkg;
    typedef enum logic [2:0] {
        CSFR_IND_PLAIN,
        CSFR_IND_POSTINC,
        CSFR_IND_POSTDEC,
        CSFR_IND_PREINC,
        CSFR_IND_OFFSET
    } csfr_ind_mode_e;

    typedef enum logic [0:0] {
        CSFR_IDLE,
        CSFR_MEM_WAIT
    } csfr_state_e;
endpackage

// ===== rtl/csfr_ptr_calc.sv
// Purpose: indirect target address and pointer follow-up value
// Assumes: 12-bit pointer, wraps modulo 4096
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module csfr_ptr_calc (
    input wire logic [11:0] pointer,
    input wire logic [7:0] offset,
    input wire csfr_pkg::csfr_ind_mode_e mode,
    output logic [11:0] target,
    output logic [11:0] next_pointer
);
    always_comb begin
        target = pointer;
        next_pointer = pointer;
        unique case (mode)
            csfr_pkg::CSFR_IND_PLAIN: begin
                target = pointer;
            end
            csfr_pkg::CSFR_IND_POSTINC: begin
                next_pointer = pointer + 12'h001;
            end
            csfr_pkg::CSFR_IND_POSTDEC: begin
                next_pointer = pointer - 12'h001;
            end
            csfr_pkg::CSFR_IND_PREINC: begin
                target = pointer + 12'h001;
                next_pointer = pointer + 12'h001;
            end
            csfr_pkg::CSFR_IND_OFFSET: begin
                // working register taken as a signed offset
                target = pointer + {{4{offset[7]}}, offset};
            end
        endcase
    end
endmodule
`default_nettype wire

// ===== rtl/csfr_bank.sv
// Purpose: core SPECIAL_FUNCTION_REGISTER bank with pointer-0 indirect access locations
// Assumes: core and data memory logic run on ref_clk
// Notes: one access in flight; data memory is reached over the mem_* port;
//        the master-clear level is synchronised, so the gated bit follows
//        it two cycles late; undefined-at-reset registers start at zero
`timescale 1ns/1ps
`default_nettype none
`include "csfr_consts.svh"
module csfr_bank (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic master_clear_pin_enable,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_access,
    input wire logic [11:0] req_addr,
    input wire logic [7:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    output logic mem_req,
    output logic mem_write,
    output logic [11:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata
);
    // implemented bits of each file entry
    function automatic logic [7:0] csfr_mask(input logic [4:0] idx,
                                             input logic clear_en);
        logic [7:0] m;
        m = `CSFR_MASK_FULL;
        unique case (idx)
            `CSFR_IDX_P0_OFFSET, `CSFR_IDX_P0_PREINC,
            `CSFR_IDX_P0_POSTDEC, `CSFR_IDX_P0_POSTINC,
            `CSFR_IDX_P0_PLAIN: begin
                m = `CSFR_MASK_NONE;
            end
            `CSFR_IDX_P0_HIGH: begin
                m = `CSFR_MASK_P0_HIGH;
            end
            `CSFR_IDX_TBLU: begin
                // bit 21 only while the master-clear function is off
                m = clear_en ? `CSFR_MASK_TBLU_GATED
                             : `CSFR_MASK_TBLU;
            end
            `CSFR_IDX_PC_LATCH_U, `CSFR_IDX_STACK_TOP_U: begin
                // upper program-address bytes are five bits wide
                m = `CSFR_MASK_UPPER5;
            end
            `CSFR_IDX_STACK_PTR: begin
                // bit 5 of the stack pointer reads zero
                m = `CSFR_MASK_STACK_PTR;
            end
            default: begin
                m = `CSFR_MASK_FULL;
            end
        endcase
        return m;
    endfunction

    // undefined-at-reset entries are still cleared for a known start
    function automatic logic [7:0] csfr_reset(input logic [4:0] idx);
        logic [7:0] r;
        r = `CSFR_RST_ZERO;
        if (idx == `CSFR_IDX_INTC_EDGES) begin
            r = `CSFR_RST_INTC_EDGES;
        end else if (idx == `CSFR_IDX_INTC_EXT) begin
            r = `CSFR_RST_INTC_EXT;
        end
        return r;
    endfunction

    // registered state
    csfr_pkg::csfr_state_e state;
    csfr_pkg::csfr_state_e next_state;
    logic [7:0] special_function_register [0:`CSFR_FILE_COUNT-1];
    logic [7:0] next_sfr [0:`CSFR_FILE_COUNT-1];
    logic clear_meta;
    logic clear_sync;
    logic pend_upd;
    logic next_pend_upd;
    logic [11:0] pend_ptr;
    logic [11:0] next_pend_ptr;
    logic next_req_ready;
    logic next_rsp_valid;
    logic [7:0] next_rsp_rdata;
    logic next_mem_req;
    logic next_mem_write;
    logic [11:0] next_mem_addr;
    logic [7:0] next_mem_wdata;

    // decode of the request in hand
    logic [11:0] eff_addr;
    logic is_ind;
    csfr_pkg::csfr_ind_mode_e ind_mode;
    logic [11:0] ptr0;
    logic [11:0] ind_target;
    logic [11:0] ind_next;
    logic [11:0] acc_addr;
    logic acc_local;
    logic acc_in_file;
    logic [4:0] acc_idx;
    logic [7:0] local_rd;
    logic loc_we;
    logic ptr_we;
    logic [11:0] ptr_val;
    logic [7:0] entry_mask [0:`CSFR_FILE_COUNT-1];

    // configuration level arrives from outside the clock domain
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            clear_meta <= 1'b0;
            clear_sync <= 1'b0;
        end else begin
            clear_meta <= master_clear_pin_enable;
            clear_sync <= clear_meta;
        end
    end

    // access-bank offsets below the split go to page 0, the rest to
    // page F from F60 upward, so F16..F5F need a full banked address
    always_comb begin
        if (req_access) begin
            if (req_addr[7:0] >= `CSFR_ACCESS_SPLIT) begin
                eff_addr = {`CSFR_SFR_PAGE, req_addr[7:0]};
            end else begin
                eff_addr = {`CSFR_GPR_PAGE, req_addr[7:0]};
            end
        end else begin
            eff_addr = req_addr;
        end
    end

    always_comb begin
        is_ind = 1'b1;
        ind_mode = csfr_pkg::CSFR_IND_PLAIN;
        unique case (eff_addr)
            `CSFR_ADDR_P0_PLAIN: ind_mode = csfr_pkg::CSFR_IND_PLAIN;
            `CSFR_ADDR_P0_POSTINC: ind_mode = csfr_pkg::CSFR_IND_POSTINC;
            `CSFR_ADDR_P0_POSTDEC: ind_mode = csfr_pkg::CSFR_IND_POSTDEC;
            `CSFR_ADDR_P0_PREINC: ind_mode = csfr_pkg::CSFR_IND_PREINC;
            `CSFR_ADDR_P0_OFFSET: ind_mode = csfr_pkg::CSFR_IND_OFFSET;
            default: is_ind = 1'b0;
        endcase
    end

    // nibble of the high byte above the low byte
    assign ptr0 = {special_function_register[`CSFR_IDX_P0_HIGH][3:0],
                   special_function_register[`CSFR_IDX_P0_LOW]};

    // one calculator serves all five modes, as one access runs at a time
    csfr_ptr_calc u_ptr_calc (
        .pointer(ptr0),
        .offset(special_function_register[`CSFR_IDX_WORK]),
        .mode(ind_mode),
        .target(ind_target),
        .next_pointer(ind_next)
    );

    assign acc_addr = is_ind ? ind_target : eff_addr;
    assign acc_local = (acc_addr >= `CSFR_SFR_LO);
    // only FE8..FFF are stored here; the rest from F16 up reads zero
    assign acc_in_file = (acc_addr[11:5] == `CSFR_FILE_TOP) &&
                         (acc_addr[4:0] >= `CSFR_FILE_FIRST);
    assign acc_idx = acc_addr[4:0] - `CSFR_FILE_FIRST;

    // an indirect location reached through the pointer reads zero too
    always_comb begin
        if (acc_in_file) begin
            local_rd = special_function_register[acc_idx] & entry_mask[acc_idx];
        end else begin
            local_rd = 8'h00;
        end
    end

    always_comb begin
        next_state = state;
        next_req_ready = req_ready;
        next_rsp_valid = 1'b0;
        next_rsp_rdata = rsp_rdata;
        next_mem_req = mem_req;
        next_mem_write = mem_write;
        next_mem_addr = mem_addr;
        next_mem_wdata = mem_wdata;
        next_pend_upd = pend_upd;
        next_pend_ptr = pend_ptr;
        loc_we = 1'b0;
        ptr_we = 1'b0;
        ptr_val = pend_ptr;
        unique case (state)
            csfr_pkg::CSFR_IDLE: begin
                // targets from F16 up are answered here in one cycle
                if (req_valid && acc_local) begin
                    next_rsp_valid = 1'b1;
                    if (req_write) begin
                        next_rsp_rdata = 8'h00;
                    end else begin
                        next_rsp_rdata = local_rd;
                    end
                    loc_we = req_write;
                    ptr_we = is_ind;
                    ptr_val = ind_next;
                end else if (req_valid) begin
                    // the pointer step is parked with the request, so the
                    // pointer only moves once the memory has answered
                    next_mem_req = 1'b1;
                    next_mem_write = req_write;
                    next_mem_addr = acc_addr;
                    next_mem_wdata = req_write ? req_wdata : 8'h00;
                    next_pend_upd = is_ind;
                    next_pend_ptr = ind_next;
                    next_req_ready = 1'b0;
                    next_state = csfr_pkg::CSFR_MEM_WAIT;
                end
            end
            csfr_pkg::CSFR_MEM_WAIT: begin
                if (mem_ack) begin
                    next_mem_req = 1'b0;
                    next_mem_write = 1'b0;
                    next_rsp_valid = 1'b1;
                    if (mem_write) begin
                        next_rsp_rdata = 8'h00;
                    end else begin
                        next_rsp_rdata = mem_rdata;
                    end
                    // step the pointer only once the access is done
                    ptr_we = pend_upd;
                    next_pend_upd = 1'b0;
                    next_req_ready = 1'b1;
                    next_state = csfr_pkg::CSFR_IDLE;
                end
            end
        endcase
    end

    // one next-value process and one register per file entry; a data
    // write to a pointer byte wins over the automatic step
    for (genvar g = 0; g < `CSFR_FILE_COUNT; g++) begin : g_entry
        assign entry_mask[g] = csfr_mask(5'(g), clear_sync);

        always_comb begin
            next_sfr[g] = special_function_register[g];
            if (ptr_we && (5'(g) == `CSFR_IDX_P0_LOW)) begin
                next_sfr[g] = ptr_val[7:0];
            end
            if (ptr_we && (5'(g) == `CSFR_IDX_P0_HIGH)) begin
                next_sfr[g] = {4'h0, ptr_val[11:8]};
            end
            if (loc_we && acc_in_file && (acc_idx == 5'(g))) begin
                next_sfr[g] = (special_function_register[g] & ~entry_mask[g]) |
                              (req_wdata & entry_mask[g]);
            end
        end

        always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
                special_function_register[g] <= csfr_reset(5'(g));
            end else begin
                special_function_register[g] <= next_sfr[g];
            end
        end
    end

    // every output of the block leaves straight from a flip-flop
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state <= csfr_pkg::CSFR_IDLE;
            pend_upd <= 1'b0;
            pend_ptr <= 12'h000;
            req_ready <= 1'b1;
            rsp_valid <= 1'b0;
            rsp_rdata <= 8'h00;
            mem_req <= 1'b0;
            mem_write <= 1'b0;
            mem_addr <= 12'h000;
            mem_wdata <= 8'h00;
        end else begin
            state <= next_state;
            pend_upd <= next_pend_upd;
            pend_ptr <= next_pend_ptr;
            req_ready <= next_req_ready;
            rsp_valid <= next_rsp_valid;
            rsp_rdata <= next_rsp_rdata;
            mem_req <= next_mem_req;
            mem_write <= next_mem_write;
            mem_addr <= next_mem_addr;
            mem_wdata <= next_mem_wdata;
        end
    end
endmodule
`default_nettype wire

// ===== tb/csfr_bank_checker.sv
// Purpose: port-level assertions on the core SPECIAL_FUNCTION_REGISTER bank
// Assumes: one clock, sync active-low reset
// Notes: sees only the top ports, attached by bind
`timescale 1ns/1ps
`default_nettype none
module csfr_bank_checker (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_access,
    input wire logic [11:0] req_addr,
    input wire logic [7:0] req_wdata,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_rdata,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [11:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic tk;
    logic ind;
    logic [7:0] lo;
    assign tk = req_valid && req_ready;
    assign lo = req_addr[7:0];
    // an access-bank offset from 60 up lands on page F as well
    assign ind = (req_access || req_addr[11:8] == 4'hF) &&
                 lo >= 8'hEB && lo <= 8'hEF;
    property p_local;
        tk && !req_access && req_addr >= 12'hF16 && !ind |=> rsp_valid;
    endproperty
    a_local: assert property (p_local) else $error("local answer late");
    property p_unimpl;
        tk && !req_write && !req_access && req_addr == 12'hFE7
            |=> rsp_rdata == 8'h00;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimpl not zero");
    property p_bank_lo;
        tk && req_access && lo < 8'h60
            |=> mem_req && mem_addr == {4'h0, $past(lo)};
    endproperty
    a_bank_lo: assert property (p_bank_lo) else $error("bank low wrong");
    property p_bank_hi;
        tk && req_access && lo >= 8'h60 && !ind |=> rsp_valid && !mem_req;
    endproperty
    a_bank_hi: assert property (p_bank_hi) else $error("bank high wrong");
    property p_rose;
        $rose(mem_req) |-> $past(tk);
    endproperty
    a_rose: assert property (p_rose) else $error("stray memory cycle");
    property p_hold;
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
            && $stable(mem_write);
    endproperty
    a_hold: assert property (p_hold) else $error("memory request moved");
    property p_ack;
        mem_req && mem_ack |=> rsp_valid && !mem_req && req_ready;
    endproperty
    a_ack: assert property (p_ack) else $error("no answer after ack");
    property p_data;
        mem_req && mem_ack && !mem_write |=> rsp_rdata == $past(mem_rdata);
    endproperty
    a_data: assert property (p_data) else $error("read data lost");
    property p_busy;
        mem_req |-> !req_ready;
    endproperty
    a_busy: assert property (p_busy) else $error("ready while busy");
    property p_wdata;
        $rose(mem_req) && mem_write |-> mem_wdata == $past(req_wdata);
    endproperty
    a_wdata: assert property (p_wdata) else $error("write data lost");
    property p_hi4;
        tk && !req_write && !req_access && req_addr == 12'hFEA
            |=> rsp_rdata[7:4] == 4'h0;
    endproperty
    a_hi4: assert property (p_hi4) else $error("ptr high set");
    c_mem_wr: cover property (mem_req && mem_ack && mem_write);
    c_unimpl: cover property (tk && req_addr == 12'hFE7);
    c_bank: cover property (tk && req_access);
endmodule
bind csfr_bank csfr_bank_checker u_chk (.ref_clk(ref_clk),
    .reset_n(reset_n), .req_valid(req_valid), .req_write(req_write),
    .req_access(req_access), .req_addr(req_addr), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_req(mem_req),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .req_wdata(req_wdata), .mem_wdata(mem_wdata));
`default_nettype wire

// ===== tb/csfr_mem_model.sv
// Purpose: data memory seen from the bank's memory port
// Assumes: byte-wide memory, content a[7:0] xor A5 at start
// Notes: wait grows with the low address bits
`timescale 1ns/1ps
`default_nettype none
module csfr_mem_model (
    input wire logic clk,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [11:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic mem_ack,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [4096];
    logic [1:0] cnt;
    initial begin
        for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'hA5;
        mem_ack = 1'b0;
        mem_rdata = 8'h00;
        cnt = 2'h0;
    end
    // data toggles outside an ack so a stale sample never matches
    always @(posedge clk) begin
        if (mem_req && !mem_ack && cnt == mem_addr[1:0]) begin
            mem_ack <= 1'b1;
            cnt <= 2'h0;
            if (mem_write) mem[mem_addr] <= mem_wdata;
            mem_rdata <= mem_write ? ~mem_rdata : mem[mem_addr];
        end else begin
            mem_ack <= 1'b0;
            cnt <= (mem_req && !mem_ack) ? cnt + 2'h1 : 2'h0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: self-checking bench for the core SPECIAL_FUNCTION_REGISTER bank
// Assumes: memory model content a[7:0] xor A5
// Notes: driver queues expectations, monitor compares at negedge
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk, reset_n, mce, req_valid, req_write, req_access;
    logic req_ready, rsp_valid, mem_req, mem_write, mem_ack;
    logic [11:0] req_addr, mem_addr, p;
    logic [7:0] req_wdata, rsp_rdata, mem_wdata, mem_rdata, w, d, r, e;
    logic [7:0] rst_exp;
    logic [7:0] q[$];
    int num_errors = 0;
    int n_tests = 0;
    csfr_bank dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .master_clear_pin_enable(mce), .req_valid(req_valid),
        .req_write(req_write), .req_access(req_access),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_req(mem_req),
        .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    csfr_mem_model u_mem (.clk(ref_clk), .mem_req(mem_req),
        .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    function automatic logic [7:0] mf(input logic [11:0] a);
        return a[7:0] ^ 8'hA5;
    endfunction
    task automatic acc(input logic wr_en, input logic ab,
        input logic [11:0] a, input logic [7:0] dat, input logic [7:0] ex);
        int n;
        n = 0;
        // let an edge pass so a lowered req_valid is seen before the next
        @(negedge ref_clk);
        while (req_ready !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 100) begin
            num_errors++;
            $display("Error %0t exp %h got %h", $time, 1'b1, req_ready);
        end
        req_valid = 1'b1;
        req_write = wr_en;
        req_access = ab;
        req_addr = a;
        req_wdata = dat;
        q.push_back(wr_en ? 8'h00 : ex);
        @(negedge ref_clk);
        req_valid = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] ex);
        acc(1'b0, 1'b0, a, 8'h00, ex);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] dat);
        acc(1'b1, 1'b0, a, dat, 8'h00);
    endtask
    task automatic tend(input string s);
        $display("test %s done", s);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial forever begin
        @(negedge ref_clk);
        if (rsp_valid === 1'b1) begin
            n_tests++;
            e = (q.size() > 0) ? q.pop_front() : ~rsp_rdata;
            if (rsp_rdata !== e) begin
                num_errors++;
                $display("Error %0t exp %h got %h", $time, e, rsp_rdata);
            end
        end
    end
    initial begin
        #100000;
        num_errors++;
        finish_test();
    end
    initial begin
        reset_n = 1'b0;
        mce = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_access = 1'b0;
        req_addr = 12'h000;
        req_wdata = 8'h00;
        void'($urandom(93941));
        repeat (16) @(negedge ref_clk);
        reset_n = 1'b1;
        for (int a = 12'hFE8; a <= 12'hFFF; a++) begin
            rst_exp = (a == 12'hFF1) ? 8'hFF :
                      (a == 12'hFF0) ? 8'hC0 : 8'h00;
            if (a < 12'hFEB || a > 12'hFEF) begin
                rd(a[11:0], rst_exp);
            end
        end
        tend("reset");
        rd(12'hFE7, 8'h00);
        wr(12'hFE7, 8'h5A);
        rd(12'hFE7, 8'h00);
        rd(12'hF16, 8'h00);
        rd(12'hFE0, 8'h00);
        tend("unimplemented");
        p = 12'h100 + 12'($urandom % 1536);
        w = 8'($urandom);
        d = 8'($urandom);
        r = 8'($urandom);
        wr(12'hFF7, d);
        rd(12'hFF7, d);
        wr(12'hFEA, {r[7:4], p[11:8]});
        wr(12'hFE9, p[7:0]);
        wr(12'hFE8, w);
        rd(12'hFEA, {4'h0, p[11:8]});
        rd(12'hFE9, p[7:0]);
        rd(12'hFEF, mf(p));
        rd(12'hFE9, p[7:0]);
        rd(12'hFEE, mf(p));
        rd(12'hFED, mf(p + 12'h1));
        rd(12'hFEC, mf(p + 12'h1));
        rd(12'hFE9, 8'(p + 12'h1));
        rd(12'hFEB, mf(p + 12'h1 + {{4{w[7]}}, w}));
        wr(12'hFEE, d);
        rd(12'hFED, mf(p + 12'h2));
        rd(12'hFEF, d);
        wr(12'hFEA, 8'h0F);
        wr(12'hFE9, 8'hE8);
        rd(12'hFEF, w);
        wr(12'hFE9, 8'hEF);
        rd(12'hFEF, 8'h00);
        tend("indirect");
        acc(1'b0, 1'b1, 12'h020, 8'h00, mf(12'h020));
        acc(1'b0, 1'b1, 12'h0E8, 8'h00, w);
        tend("access bank");
        wr(12'hFF8, 8'hFF);
        rd(12'hFF8, 8'h3F);
        mce = 1'b1;
        repeat (4) @(negedge ref_clk);
        rd(12'hFF8, 8'h1F);
        wr(12'hFF8, 8'h00);
        mce = 1'b0;
        repeat (4) @(negedge ref_clk);
        rd(12'hFF8, 8'h20);
        tend("gated bit");
        repeat (10) @(negedge ref_clk);
        if (q.size() != 0) begin
            num_errors++;
            $display("Error %0t exp %h got %h", $time, 0, q.size());
        end
        finish_test();
    end
endmodule
`default_nettype wire
